// [hdl/tic_pkg.sv]
// package: constants, register map and types for trigger input conditioning
package tic_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned FILT_STEP_US = 100;
  localparam int unsigned FILT_STEP_CYC = FILT_STEP_US * CLK_MHZ;
  localparam int unsigned FILT_CNT_W = 17;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_FILT = 4'h0;
  localparam logic [3:0] REG_ENC_CTRL = 4'h4;
  localparam logic [3:0] REG_ENC_RES = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hC;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned ENC_EN_BIT = 0;
  localparam int unsigned ENC_ZCNT_BIT = 1;
  localparam int unsigned ENC_SRCZ_BIT = 2;
  localparam int unsigned ENC_STEPSTART_BIT = 3;
  localparam int unsigned ST_LINE_LSB = 0;
  localparam int unsigned ST_ROT_LSB = 16;

  // ---------------------------------------------------------------
  // reset values and filter code limit
  // ---------------------------------------------------------------
  localparam logic [2:0] FILT_RST = 3'h0;
  localparam logic [15:0] ENC_RES_RST = 16'h0001;
  localparam logic [2:0] FILT_MAX = 3'h4;

  typedef enum logic [1:0] {
    TIC_BUS_IDLE,
    TIC_BUS_ACK
  } tic_bus_state_type;

  // encoder control fields travel together
  typedef struct packed {
    logic step_start;
    logic src_z;
    logic z_count;
    logic enable;
  } tic_enc_cfg_type;

endpackage

// [hdl/tic_debounce.sv]
// one symmetric debounce filter for a single trigger line
`timescale 1ns/1ps
`default_nettype none
module tic_debounce
  import tic_pkg::*;
#(
  parameter int unsigned CNT_W = FILT_CNT_W
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic raw,
  input wire logic [CNT_W-1:0] width,
  output logic level,
  output logic rise
);

  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic level_q, level_d;
  logic rise_q, rise_d;

  // ---------------------------------------------------------------
  // qualification
  // ---------------------------------------------------------------
  // count while raw differs from the filtered level; any return resets
  always_comb begin
    cnt_d = '0;
    level_d = level_q;
    rise_d = 1'b0;
    if (raw != level_q) begin
      if (cnt_q + CNT_W'(1) >= width) begin
        level_d = raw; // [RULE_01] [RULE_02]
        rise_d = raw; // [RULE_03]
      end else begin
        cnt_d = cnt_q + CNT_W'(1);
      end
    end
    // raw back to level before width: cnt_d stays 0 [RULE_12]
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
      level_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      level_q <= level_d;
      rise_q <= rise_d;
    end
  end

  assign level = level_q;
  assign rise = rise_q;

endmodule
`default_nettype wire

// [hdl/tic_top.sv]
// trigger input conditioning: debounce filters, encoder trigger, registers
//
// How it works
// RULE_01 - filtered trigger goes active after raw high for full filter width
// RULE_02 - filtered trigger goes inactive after raw low for full filter width
// RULE_03 - measurement start pulses when filtered input qualifies active
// RULE_04 - filter width is 100..500 us in 100 us steps, 100 after reset
// RULE_05 - line 0 filter width is used by every line's filter
// RULE_06 - encoder trigger enable is off after reset and blocks triggers
// RULE_07 - resolution register holds 1..65535 phase A pulses, 1 after reset
// RULE_08 - with index counting on, Z pulse marks a full rotation
// RULE_09 - with index counting off, A count reaching resolution is a rotation
// RULE_10 - trigger source picks phase A (default) or phase Z
// RULE_11 - in step-start mode encoder pulses ignored until trigger qualifies
// RULE_12 - a glitch shorter than the width restarts qualification
`timescale 1ns/1ps
`default_nettype none
module tic_top
  import tic_pkg::*;
#(
  parameter int unsigned LINES = 2
) (
  input wire logic clock,
  input wire logic resetn,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // pins
  input wire logic [LINES-1:0] trig_in,
  input wire logic enc_a,
  input wire logic enc_z,
  // results
  output logic [LINES-1:0] trig_level,
  output logic [LINES-1:0] meas_start,
  output logic enc_trigger,
  output logic rotation
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // filter code to cycle count: (code+1) * 100 us
  function automatic logic [FILT_CNT_W-1:0] filt_cycles(
    input logic [2:0] code
  );
    logic [FILT_CNT_W-1:0] steps;
    steps = FILT_CNT_W'(code) + FILT_CNT_W'(1);
    filt_cycles = FILT_CNT_W'(steps * FILT_CNT_W'(FILT_STEP_CYC));
  endfunction

  // rising edge of a synchronised pin against its previous sample;
  // both encoder phases use it so the two edges line up in time
  function automatic logic pin_rose(
    input logic now_v,
    input logic last_v
  );
    pin_rose = now_v && !last_v;
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // every pin passes two flops; only the second stage feeds logic, so
  // a metastable first stage never reaches the counters
  logic [LINES+1:0] sync1_q, sync2_q;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {enc_z, enc_a, trig_in};
      sync2_q <= sync1_q;
    end
  end

  // split the second stage back into its pins
  logic [LINES-1:0] trig_s;
  logic a_s, z_s;
  assign trig_s = sync2_q[LINES-1:0];
  assign a_s = sync2_q[LINES];
  assign z_s = sync2_q[LINES+1];

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  // configuration state; the bus answers from registers so no path runs
  // from the request pins straight to readdata or waitrequest
  logic [2:0] filt_q, filt_d;
  tic_enc_cfg_type cfg_q, cfg_d;
  logic [15:0] res_q, res_d;
  tic_bus_state_type bus_q, bus_d;
  logic [31:0] rdata_q, rdata_d;
  logic wait_q, wait_d;
  logic [15:0] rot_cnt_q, rot_cnt_d;

  // one wait cycle then acknowledge; simple and timing-friendly
  always_comb begin
    filt_d = filt_q;
    cfg_d = cfg_q;
    res_d = res_q;
    bus_d = bus_q;
    rdata_d = rdata_q;
    wait_d = 1'b1;
    // a request is taken only from idle; the acknowledge cycle ignores it
    case (bus_q)
      TIC_BUS_IDLE: begin
        if (avs_read || avs_write) begin
          bus_d = TIC_BUS_ACK;
          wait_d = 1'b0;
          rdata_d = '0;
          if (avs_write) begin
            case (avs_address)
              REG_FILT: begin
                // out-of-range codes are ignored [RULE_04]
                if (avs_byteenable[0] &&
                    avs_writedata[2:0] <= FILT_MAX) begin
                  filt_d = avs_writedata[2:0];
                end
              end
              REG_ENC_CTRL: begin
                if (avs_byteenable[0]) begin
                  // field by field so the bit map stays in the package
                  cfg_d.enable = avs_writedata[ENC_EN_BIT];
                  cfg_d.z_count = avs_writedata[ENC_ZCNT_BIT];
                  cfg_d.src_z = avs_writedata[ENC_SRCZ_BIT];
                  cfg_d.step_start = avs_writedata[ENC_STEPSTART_BIT];
                end
              end
              REG_ENC_RES: begin
                // zero is not a legal resolution [RULE_07]
                if (avs_byteenable[1:0] == 2'h3 &&
                    avs_writedata[15:0] != 16'h0000) begin
                  res_d = avs_writedata[15:0];
                end
              end
              default: begin
              end
            endcase
          end else begin
            case (avs_address)
              REG_FILT: rdata_d = {29'h0, filt_q};
              REG_ENC_CTRL: begin
                rdata_d[ENC_EN_BIT] = cfg_q.enable;
                rdata_d[ENC_ZCNT_BIT] = cfg_q.z_count;
                rdata_d[ENC_SRCZ_BIT] = cfg_q.src_z;
                rdata_d[ENC_STEPSTART_BIT] = cfg_q.step_start;
              end
              REG_ENC_RES: rdata_d = {16'h0, res_q};
              REG_STATUS: begin
                rdata_d[ST_LINE_LSB +: LINES] = trig_level;
                rdata_d[ST_ROT_LSB +: 16] = rot_cnt_q;
              end
              default: rdata_d = '0;
            endcase
          end
        end
      end
      TIC_BUS_ACK: begin
        bus_d = TIC_BUS_IDLE;
      end
      default: bus_d = TIC_BUS_IDLE;
    endcase
  end

  // register the bus and configuration state
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      filt_q <= FILT_RST; // [RULE_04]
      cfg_q <= '0; // [RULE_06]
      res_q <= ENC_RES_RST; // [RULE_07]
      bus_q <= TIC_BUS_IDLE;
      rdata_q <= '0;
      wait_q <= 1'b1;
    end else begin
      filt_q <= filt_d;
      cfg_q <= cfg_d;
      res_q <= res_d;
      bus_q <= bus_d;
      rdata_q <= rdata_d;
      wait_q <= wait_d;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;

  // ---------------------------------------------------------------
  // debounce filters
  // ---------------------------------------------------------------
  // one width for all lines: a per-line setting would cost a compare
  // per line for no gain, since line 0 decides it anyway
  logic [FILT_CNT_W-1:0] width;
  assign width = filt_cycles(filt_q); // shared by all lines [RULE_05]

  logic [LINES-1:0] lvl, rise;
  genvar gi;
  generate
    for (gi = 0; gi < LINES; gi++) begin : g_line
      tic_debounce #(
        .CNT_W(FILT_CNT_W)
      ) u_deb (
        .clock(clock),
        .resetn(resetn),
        .raw(trig_s[gi]),
        .width(width),
        .level(lvl[gi]),
        .rise(rise[gi])
      );
    end
  endgenerate

  // filtered levels and start pulses come straight from filter flops
  assign trig_level = lvl;
  assign meas_start = rise; // [RULE_03]

  // ---------------------------------------------------------------
  // encoder
  // ---------------------------------------------------------------
  logic a_prev_q, z_prev_q, armed_q, armed_d;
  logic [15:0] a_cnt_q, a_cnt_d;
  logic etrig_q, etrig_d, rot_q, rot_d;
  logic a_edge, z_edge, count_ok;

  // edges are taken after the synchroniser, so a pin change reaches
  // the edge detect one clock after the first flop samples it
  assign a_edge = pin_rose(a_s, a_prev_q);
  assign z_edge = pin_rose(z_s, z_prev_q);
  // step-start waits for line 0 to qualify [RULE_11]
  assign count_ok = cfg_q.enable && (!cfg_q.step_start || armed_q);

  // arming, pulse counting and rotation detection; an A edge and a Z
  // edge in one cycle give one trigger pulse and at most one rotation
  always_comb begin
    armed_d = armed_q;
    a_cnt_d = a_cnt_q;
    rot_cnt_d = rot_cnt_q;
    etrig_d = 1'b0;
    rot_d = 1'b0;
    if (!cfg_q.enable || !cfg_q.step_start) begin
      armed_d = 1'b0;
    end else if (rise[0]) begin
      armed_d = 1'b1; // [RULE_11]
    end
    if (!cfg_q.enable) begin
      a_cnt_d = '0; // no triggers while disabled [RULE_06]
    end else if (count_ok) begin
      if (a_edge) begin
        if (!cfg_q.src_z) begin
          etrig_d = 1'b1; // [RULE_10]
        end
        if (!cfg_q.z_count && a_cnt_q + 16'h0001 >= res_q) begin
          a_cnt_d = '0;
          rot_d = 1'b1; // [RULE_09]
        end else begin
          a_cnt_d = a_cnt_q + 16'h0001;
        end
      end
      if (z_edge) begin
        if (cfg_q.src_z) begin
          etrig_d = 1'b1; // [RULE_10]
        end
        if (cfg_q.z_count) begin
          a_cnt_d = '0;
          rot_d = 1'b1; // [RULE_08]
        end
      end
    end
    if (rot_d) begin
      rot_cnt_d = rot_cnt_q + 16'h0001;
    end
  end

  // previous samples start low like idle pins, so no edge after reset
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      a_prev_q <= 1'b0;
      z_prev_q <= 1'b0;
      armed_q <= 1'b0;
      a_cnt_q <= '0;
      rot_cnt_q <= '0;
      etrig_q <= 1'b0;
      rot_q <= 1'b0;
    end else begin
      a_prev_q <= a_s;
      z_prev_q <= z_s;
      armed_q <= armed_d;
      a_cnt_q <= a_cnt_d;
      rot_cnt_q <= rot_cnt_d;
      etrig_q <= etrig_d;
      rot_q <= rot_d;
    end
  end

  assign enc_trigger = etrig_q;
  assign rotation = rot_q;

endmodule
`default_nettype wire

// [sim/tic_encoder_model.sv]
// model of the far side: trigger lines and a rotary encoder
`timescale 1ns/1ps
`default_nettype none
module tic_encoder_model (
  input wire logic clock,
  output logic [1:0] trig_in,
  output logic enc_a,
  output logic enc_z
);
  // pins idle low; every change lands just after a clock edge
  initial begin
    trig_in = 2'h0;
    enc_a = 1'b0;
    enc_z = 1'b0;
  end
  task automatic line(input int n, input logic v);
    @(posedge clock);
    trig_in[n] <= v;
  endtask
  // 8-cycle phases clear the two-flop synchroniser with margin
  task automatic pulse(input logic z, input int n);
    repeat (n) begin
      @(posedge clock);
      if (z) enc_z <= 1'b1;
      else enc_a <= 1'b1;
      repeat (8) @(posedge clock);
      enc_a <= 1'b0;
      enc_z <= 1'b0;
      repeat (8) @(posedge clock);
    end
  endtask
endmodule
`default_nettype wire

// [sim/tic_top_assertions.sv]
// checker: port-level timing of filters and encoder pulses
`timescale 1ns/1ps
`default_nettype none
module tic_top_assertions
  import tic_pkg::*;
#(
  parameter int unsigned LINES = 2
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [LINES-1:0] trig_in,
  input wire logic [LINES-1:0] trig_level,
  input wire logic [LINES-1:0] meas_start,
  input wire logic enc_a,
  input wire logic enc_z,
  input wire logic enc_trigger,
  input wire logic rotation
);
  localparam logic [16:0] W_MIN = 17'h04E20;
  logic [16:0] hi0_q, lo0_q, hi1_q;
  logic [7:0] age_q;
  logic ea_q, ez_q;
  // raw run lengths saturate so long idles never wrap
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hi0_q <= 17'h00000;
      lo0_q <= 17'h00000;
      hi1_q <= 17'h00000;
      age_q <= 8'hFF;
      ea_q <= 1'b0;
      ez_q <= 1'b0;
    end else begin
      hi0_q <= trig_in[0] ? hi0_q + {16'h0000, ~&hi0_q} : 17'h00000;
      lo0_q <= !trig_in[0] ? lo0_q + {16'h0000, ~&lo0_q} : 17'h00000;
      hi1_q <= trig_in[1] ? hi1_q + {16'h0000, ~&hi1_q} : 17'h00000;
      ea_q <= enc_a;
      ez_q <= enc_z;
      age_q <= ((enc_a & ~ea_q) | (enc_z & ~ez_q)) ? 8'h00 :
               age_q + {7'h00, ~&age_q};
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_rise_hi; $rose(trig_level[0]) |-> hi0_q >= W_MIN; endproperty
  a_rise_hi: assert property (p_rise_hi) else $error("early rise");
  property p_fall_lo; $fell(trig_level[0]) |-> lo0_q >= W_MIN; endproperty
  a_fall_lo: assert property (p_fall_lo) else $error("early fall");
  property p_line1; $rose(trig_level[1]) |-> hi1_q >= W_MIN; endproperty
  a_line1: assert property (p_line1) else $error("line 1 early");
  property p_start; meas_start[0] |-> $rose(trig_level[0]); endproperty
  a_start: assert property (p_start) else $error("stray start");
  property p_start1; $rose(trig_level[1]) |-> meas_start[1]; endproperty
  a_start1: assert property (p_start1) else $error("no start");
  property p_enc; enc_trigger |-> age_q <= 8'h08; endproperty
  a_enc: assert property (p_enc) else $error("trigger w/o edge");
  property p_rot; rotation |-> age_q <= 8'h08; endproperty
  a_rot: assert property (p_rot) else $error("rotation w/o edge");
  property p_ack;
    (avs_read || avs_write) && avs_waitrequest |-> ##[1:3] !avs_waitrequest;
  endproperty
  a_ack: assert property (p_ack) else $error("bus not answered");
  c_rise: cover property ($rose(trig_level[0]));
  c_enc: cover property (enc_trigger);
  c_rot: cover property (rotation);
endmodule
bind tic_top tic_top_assertions #(.LINES(LINES)) i_tic_top_assertions (
  .clock(clock), .resetn(resetn), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .trig_in(trig_in), .trig_level(trig_level), .meas_start(meas_start),
  .enc_a(enc_a), .enc_z(enc_z), .enc_trigger(enc_trigger),
  .rotation(rotation));
`default_nettype wire

// [sim/tic_top_bench.sv]
// bench: registers, encoder triggers and trigger filters
`timescale 1ns/1ps
`default_nettype none
module tic_top_bench
  import tic_pkg::*;
;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, enc_a, enc_z, enc_trigger, rotation;
  logic [1:0] trig_in, trig_level, meas_start;
  int error_cnt = 0;
  int checks_done = 0;
  int n_trig = 0;
  int n_rot = 0;
  int n_st = 0;
  initial begin
    forever #2.5 clock = ~clock;
  end
  tic_top #(.LINES(2)) i_tic_top (.clock(clock), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .trig_in(trig_in), .enc_a(enc_a), .enc_z(enc_z),
    .trig_level(trig_level), .meas_start(meas_start),
    .enc_trigger(enc_trigger), .rotation(rotation));
  tic_encoder_model i_tic_encoder_model (.clock(clock), .trig_in(trig_in),
    .enc_a(enc_a), .enc_z(enc_z));
  // tally one-cycle result pulses
  always @(posedge clock) begin
    n_trig <= n_trig + (enc_trigger === 1'b1);
    n_rot <= n_rot + (rotation === 1'b1);
    n_st <= n_st + (meas_start[0] === 1'b1);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // held until waitrequest is seen low; read data taken at that edge;
  // only the watchdog ends a wait that never gets an answer
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // cycles from pin change to filtered change must lie between w and w plus 8
  task automatic lag(input int ln, input logic v, input int w);
    int c;
    c = 0;
    i_tic_encoder_model.line(ln, v);
    while (trig_level[ln] !== v && c < w + 50) begin
      @(posedge clock);
      c++;
    end
    chk(32'(c >= w && c <= w + 8), 32'h1);
  endtask
  task automatic t_regs();
    bus(0, REG_FILT, 0);
    chk(q, 32'h0);
    bus(0, REG_ENC_CTRL, 0);
    chk(q, 32'h0);
    bus(0, REG_ENC_RES, 0);
    chk(q, 32'h1);
    bus(0, 4'h2, 0);
    chk(q, 32'h0);
    bus(1, REG_FILT, 32'h5);
    bus(0, REG_FILT, 0);
    chk(q, 32'h0);
    bus(1, REG_FILT, 32'h4);
    bus(0, REG_FILT, 0);
    chk(q, 32'h4);
    bus(1, REG_FILT, 32'h0);
    bus(1, REG_ENC_RES, 32'h0);
    bus(0, REG_ENC_RES, 0);
    chk(q, 32'h1);
    bus(1, REG_ENC_RES, 32'hFFFF);
    bus(0, REG_ENC_RES, 0);
    chk(q, 32'hFFFF);
  endtask
  task automatic t_enc();
    int t, r;
    t = n_trig;
    i_tic_encoder_model.pulse(0, 3);
    repeat (20) @(posedge clock);
    chk(32'(n_trig - t), 32'h0);
    bus(1, REG_ENC_RES, 32'h3);
    bus(1, REG_ENC_CTRL, 32'h1);
    t = n_trig;
    r = n_rot;
    i_tic_encoder_model.pulse(0, 6);
    repeat (20) @(posedge clock);
    chk(32'(n_trig - t), 32'h6);
    chk(32'(n_rot - r), 32'h2);
    bus(1, REG_ENC_CTRL, 32'h7);
    bus(0, REG_ENC_CTRL, 0);
    chk(q, 32'h7);
    t = n_trig;
    r = n_rot;
    i_tic_encoder_model.pulse(0, 2);
    i_tic_encoder_model.pulse(1, 1);
    repeat (20) @(posedge clock);
    chk(32'(n_trig - t), 32'h1);
    chk(32'(n_rot - r), 32'h1);
    bus(1, REG_ENC_CTRL, 32'h9);
    t = n_trig;
    i_tic_encoder_model.pulse(0, 2);
    repeat (20) @(posedge clock);
    chk(32'(n_trig - t), 32'h0);
    // two rotations by A count plus one by Z, both lines low
    bus(0, REG_STATUS, 0);
    chk(q, 32'h00030000);
  endtask
  // a glitch first: if it left a partial count the rise comes early
  task automatic t_filter();
    int s, t;
    s = n_st;
    i_tic_encoder_model.line(0, 1'b1);
    repeat (5000) @(posedge clock);
    i_tic_encoder_model.line(0, 1'b0);
    repeat (50) @(posedge clock);
    chk({31'h0, trig_level[0]}, 32'h0);
    lag(0, 1'b1, 20000);
    repeat (3) @(posedge clock);
    chk(32'(n_st - s), 32'h1);
    t = n_trig;
    i_tic_encoder_model.pulse(0, 1);
    repeat (20) @(posedge clock);
    chk(32'(n_trig - t), 32'h1);
    lag(0, 1'b0, 20000);
  endtask
  task automatic t_width();
    bus(1, REG_FILT, 32'h1);
    lag(1, 1'b1, 40000);
    // line 1 high, line 0 back low, rotation count unchanged
    bus(0, REG_STATUS, 0);
    chk(q, 32'h00030002);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    t_regs();
    t_enc();
    t_filter();
    t_width();
    test_done();
  end
  // watchdog: a clean run takes about 86000 cycles
  initial begin
    repeat (95000) @(posedge clock);
    error_cnt++;
    test_done();
  end
endmodule
`default_nettype wire
